// File: rtl/bpp_pkg.sv
// Purpose: constants for the eight-pin bidirectional port block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register offsets and the control register are local choices
// How it works
// - eight pins, bit x of every register controls pin x
// - three software registers: data latch, direction, output type
// - reset clears all registers; pins become inputs with pull-up, no interrupt
// - direction 0 makes an input; data read returns pin level
// - direction 1 makes an output; latch value drives the pin
// - output pin reads return the stored latch value
// - latch 0 drives low; latch 1 drives high or floats if open-drain
// - output type 0 selects open-drain, 1 push-pull
// - input, type 0, data 0: pull-up on, no interrupt
// - input, type 0, data 1: pull-up off, no interrupt
// - input, type 1, data 0: pull-up on, interrupt connected
// - input, type 1, data 1: analog input to converter
// - pin event interrupts only if pin configured and global enable set
// - trigger per port: falling edge, rising edge or low level
// - low-power states keep configuration; pin interrupts wake the device
// - open-drain only disables the high-side driver
// - alternate function active only once pin bits configure it
// - input pins use latch bits for pull-up, interrupt, analog selection
package bpp_pkg;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_DIR = 12'h004;
  localparam logic [11:0] OFS_TYPE = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00c;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'hff;
  localparam logic [2:0] RST_CTRL = 3'h0;
  // control register fields
  localparam int unsigned CTRL_IRQ_EN_BIT = 0;
  localparam int unsigned CTRL_TRIG_LSB = 1;
  localparam int unsigned CTRL_TRIG_MSB = 2;
  typedef enum logic [1:0] {
    BPP_TRIG_FALL = 2'b00,
    BPP_TRIG_RISE = 2'b01,
    BPP_TRIG_LOW = 2'b10
  } bpp_trig_e;
endpackage : bpp_pkg

// File: rtl/bpp_port.sv
// Purpose: eight-pin bidirectional port with input, analog and output modes
// Assumes: pins are asynchronous; one clock pclk at 40 MHz
// Notes: no interrupt logic beyond the level/pulse request sent outward
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module bpp_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_en,
  output logic [7:0] analog_sel,
  output logic irq_req
);

  logic [7:0] port_data_latch_ff;
  logic [7:0] port_direction_ff;
  logic [7:0] port_output_type_ff;
  logic global_irq_enable_ff;
  logic [1:0] trig_mode_ff;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] pin_prev_ff;
  logic [7:0] nxt_pin_out;
  logic [7:0] nxt_pin_oe;
  logic [7:0] nxt_pullup;
  logic [7:0] nxt_analog;
  logic [7:0] irq_pin_en;
  logic [7:0] pin_event;
  logic [7:0] rd_data_view;
  logic nxt_irq;
  logic acc;
  logic wr_ok;
  logic mapped;
  logic [31:0] nxt_prdata;

  assign acc = psel && penable;
  assign mapped = (paddr == bpp_pkg::OFS_DATA) || (paddr == bpp_pkg::OFS_DIR) ||
                  (paddr == bpp_pkg::OFS_TYPE) || (paddr == bpp_pkg::OFS_CTRL);
  // write lands only on the access cycle with byte 0 enabled
  assign wr_ok = acc && pwrite && mapped && pstrb[0];

  // pin levels are asynchronous, so two flops before any use
  // reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= bpp_pkg::RST_PULLUP;
      sync2_ff <= bpp_pkg::RST_PULLUP;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_ff <= bpp_pkg::RST_PULLUP;
    else
      pin_prev_ff <= sync2_ff;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_data_latch_ff <= bpp_pkg::RST_REG;
    else if (wr_ok && paddr == bpp_pkg::OFS_DATA)
      port_data_latch_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_direction_ff <= bpp_pkg::RST_REG;
    else if (wr_ok && paddr == bpp_pkg::OFS_DIR)
      port_direction_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_output_type_ff <= bpp_pkg::RST_REG;
    else if (wr_ok && paddr == bpp_pkg::OFS_TYPE)
      port_output_type_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_irq_enable_ff <= bpp_pkg::RST_CTRL[0];
      trig_mode_ff <= bpp_pkg::RST_CTRL[2:1];
    end
    else if (wr_ok && paddr == bpp_pkg::OFS_CTRL)
    begin
      global_irq_enable_ff <= pwdata[bpp_pkg::CTRL_IRQ_EN_BIT];
      trig_mode_ff <= pwdata[bpp_pkg::CTRL_TRIG_MSB:bpp_pkg::CTRL_TRIG_LSB];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < bpp_pkg::NUM_PINS; gi++)
    begin : g_pin
      logic dir;
      logic typ;
      logic dat;
      assign dir = port_direction_ff[gi];
      assign typ = port_output_type_ff[gi];
      assign dat = port_data_latch_ff[gi];
      assign nxt_pin_out[gi] = dir & dat;
      // open-drain drops only the high side
      assign nxt_pin_oe[gi] = dir & (typ | ~dat);
      assign nxt_pullup[gi] = ~dir & ~dat;
      assign nxt_analog[gi] = ~dir & typ & dat;
      assign irq_pin_en[gi] = ~dir & typ & ~dat;
      assign rd_data_view[gi] = dir ? dat : sync2_ff[gi];
    end
  endgenerate

  always_comb
  begin
    case (bpp_pkg::bpp_trig_e'(trig_mode_ff))
      bpp_pkg::BPP_TRIG_FALL: pin_event = pin_prev_ff & ~sync2_ff;
      bpp_pkg::BPP_TRIG_RISE: pin_event = ~pin_prev_ff & sync2_ff;
      bpp_pkg::BPP_TRIG_LOW: pin_event = ~sync2_ff;
      default: pin_event = 8'h00;
    endcase
  end

  // gated by pin mode and global enable
  // request stays live in low power since no clock gating here
  assign nxt_irq = global_irq_enable_ff && |(pin_event & irq_pin_en);

  // alternate use needs the same register setup; no override path exists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= bpp_pkg::RST_REG;
      pin_oe <= bpp_pkg::RST_REG;
      pullup_en <= bpp_pkg::RST_PULLUP;
      analog_sel <= bpp_pkg::RST_REG;
      irq_req <= 1'b0;
    end
    else
    begin
      pin_out <= nxt_pin_out;
      pin_oe <= nxt_pin_oe;
      pullup_en <= nxt_pullup;
      analog_sel <= nxt_analog;
      irq_req <= nxt_irq;
    end
  end

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      bpp_pkg::OFS_DATA: nxt_prdata[7:0] = rd_data_view;
      bpp_pkg::OFS_DIR: nxt_prdata[7:0] = port_direction_ff;
      bpp_pkg::OFS_TYPE: nxt_prdata[7:0] = port_output_type_ff;
      bpp_pkg::OFS_CTRL: nxt_prdata[2:0] = {trig_mode_ff, global_irq_enable_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // setup cycle registers read data; access cycle answers with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
        prdata <= nxt_prdata;
    end
  end

  a_reset_state: assert property (@(posedge pclk)
    $rose(presetn) |-> (pin_oe == 8'h00 && analog_sel == 8'h00))
    else $error("port not in input state after reset");

  a_reset_pull: assert property (@(posedge pclk)
    $rose(presetn) |-> (pullup_en == bpp_pkg::RST_PULLUP && pin_out == bpp_pkg::RST_REG && !irq_req))
    else $error("pull-up or drive wrong after reset");

  a_input_undriven: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_oe & ~$past(port_direction_ff)) == 8'h00)
    else $error("input pin driven");

  a_oe_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(port_direction_ff & port_output_type_ff) & ~pin_oe) == 8'h00)
    else $error("push-pull pin not driven");

  a_push_level: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_out ^ $past(port_data_latch_ff)) & $past(port_direction_ff & port_output_type_ff)) == 8'h00)
    else $error("push-pull level differs from latch");

  a_od_high_float: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_oe & $past(port_direction_ff & ~port_output_type_ff & port_data_latch_ff)) == 8'h00)
    else $error("open drain drove high");

  a_drive_low: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(port_direction_ff & ~port_data_latch_ff) & ~(pin_oe & ~pin_out)) == 8'h00)
    else $error("latch zero not driven low");

  a_analog_mode: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(port_direction_ff) & analog_sel) == 8'h00)
    else $error("analog selected on output");

  a_analog_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (analog_sel & (pin_oe | pullup_en)) == 8'h00)
    else $error("analog pin driven or pulled");

  a_pull_select: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(~port_direction_ff & ~port_data_latch_ff) & ~pullup_en) == 8'h00)
    else $error("pull-up missing");

  a_pull_off: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(port_data_latch_ff) & pullup_en) == 8'h00)
    else $error("pull-up left on");

  sequence s_irq_armed;
    global_irq_enable_ff && irq_pin_en != 8'h00;
  endsequence

  a_irq_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(global_irq_enable_ff) |-> !irq_req)
    else $error("interrupt without global enable");

  a_irq_pin_mode: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> $past(irq_pin_en != 8'h00))
    else $error("interrupt from unarmed pin");

  a_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_irq_armed ##0 (trig_mode_ff == bpp_pkg::BPP_TRIG_LOW &&
    (irq_pin_en & ~sync2_ff) != 8'h00) |=> irq_req)
    else $error("low level not requested");

  a_irq_fall: assert property (@(posedge pclk) disable iff (!presetn)
    s_irq_armed ##0 (trig_mode_ff == bpp_pkg::BPP_TRIG_FALL &&
    (irq_pin_en & pin_prev_ff & ~sync2_ff) != 8'h00) |=> irq_req)
    else $error("falling edge not requested");

  a_irq_rise: assert property (@(posedge pclk) disable iff (!presetn)
    s_irq_armed ##0 (trig_mode_ff == bpp_pkg::BPP_TRIG_RISE &&
    (irq_pin_en & ~pin_prev_ff & sync2_ff) != 8'h00) |=> irq_req)
    else $error("rising edge not requested");

  a_irq_none: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> $past(trig_mode_ff) != 2'h3)
    else $error("interrupt with no trigger selected");

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_access |-> pready)
    else $error("no ready in access cycle");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == bpp_pkg::OFS_DIR) |=> port_direction_ff == $past(pwdata[7:0]))
    else $error("direction write lost");

  a_type_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == bpp_pkg::OFS_TYPE) |=> port_output_type_ff == $past(pwdata[7:0]))
    else $error("output type write lost");

  a_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == bpp_pkg::OFS_DATA) |=> port_data_latch_ff == $past(pwdata[7:0]))
    else $error("latch write lost");

  a_config_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ok |=> {port_data_latch_ff, port_direction_ff, port_output_type_ff} ==
      $past({port_data_latch_ff, port_direction_ff, port_output_type_ff}) &&
      {trig_mode_ff, global_irq_enable_ff} == $past({trig_mode_ff, global_irq_enable_ff}))
    else $error("configuration changed without a write");

endmodule : bpp_port

// File: tb/bpp_pin_model.sv
// Purpose: pad-side model that resolves each pin level
// Assumes: bench drives ext_en and ext_val away from the sampling edge
// Notes: a pad with no driver and no pull-up shows the inverse of its last level
`timescale 1ns/1ps
module bpp_pin_model (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] last_ff = 8'h00;
  // a floating pad keeps the inverse of its last driven level instead of toggling
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i] || ext_en[i] || pullup_en[i])
        last_ff[i] <= pin_in[i];
    end
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_ff[i];
    end
  end
endmodule : bpp_pin_model

// File: tb/bpp_port_test.sv
// Purpose: self-checking bench for the eight-pin port
// Assumes: zero-wait APB slave, one port, 40 MHz clock
// Notes: reads are noted in a queue and judged by a monitor
`timescale 1ns/1ps
module bpp_port_test;
  localparam logic [11:0] A_D = bpp_pkg::OFS_DATA;
  localparam logic [11:0] A_R = bpp_pkg::OFS_DIR;
  localparam logic [11:0] A_T = bpp_pkg::OFS_TYPE;
  localparam logic [11:0] A_C = bpp_pkg::OFS_CTRL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, irq_req, seen;
  logic [7:0] pin_in, pin_out, pin_oe, pullup_en, analog_sel, v, t, d;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [32:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  always #12.5 pclk = ~pclk;
  bpp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .pullup_en, .analog_sel, .irq_req);
  bpp_pin_model model (.pclk, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task chk(input logic [32:0] s, input logic [32:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // reads note {error, data}; unmapped places answer with error and zero
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    if (!w)
      exp_q.push_back({a > A_C, a > A_C ? 32'h0 : dat});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      $display("Error at %0t: no pready", $time);
      err_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task settle;
    repeat (4) @(posedge pclk);
  endtask : settle
  task wirq(input logic e);
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge pclk);
      seen = seen | (irq_req === 1'b1);
    end
    chk(seen, e);
  endtask : wirq
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial
  begin
    void'($urandom(59));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk({pullup_en, pin_oe, analog_sel, irq_req}, 25'h1fe0000);
    apb(0, A_D, 32'hff);
    apb(0, A_R, 32'h0);
    apb(0, A_T, 32'h0);
    apb(0, A_C, 32'h0);
    apb(0, 12'h010, 32'h0);
    // a write with the low byte strobe clear is refused
    pstrb <= 4'h0;
    apb(1, A_R, 32'hff);
    pstrb <= 4'hf;
    apb(0, A_R, 32'h0);
    v = 8'($urandom);
    apb(1, A_R, 32'hff);
    apb(1, A_T, 32'hff);
    apb(1, A_D, {24'h0, v});
    settle();
    chk({pin_oe, pin_out}, {8'hff, v});
    apb(0, A_D, {24'h0, v});
    apb(1, A_T, 32'h0);
    settle();
    chk({pin_oe, pin_out & pin_oe}, {~v, 8'h00});
    apb(0, A_D, {24'h0, v});
    // latch from output mode selects pull-up
    apb(1, A_R, 32'h0);
    settle();
    chk({pullup_en, analog_sel}, {~v, 8'h00});
    ext_en <= 8'hff;
    for (int i = 0; i < 8; i++)
    begin
      {t, d, v} = 24'($urandom);
      d = (d & ~t) | (t & (8'h01 << i));
      apb(1, A_T, 32'h0);
      apb(1, A_D, {24'h0, d});
      apb(1, A_T, {24'h0, t});
      ext_val <= v;
      settle();
      chk({pullup_en, analog_sel}, {~d, t & d});
      apb(0, A_D, {24'h0, v});
    end
    apb(1, A_T, 32'h01);
    apb(1, A_D, 32'h0);
    ext_en <= 8'h01;
    for (int m = 0; m < 3; m++)
    begin
      ext_val <= {7'h0, m != 1};
      settle();
      settle();
      apb(1, A_C, 32'(m * 2 + 1));
      wirq(1'b0);
      ext_val <= {7'h0, m == 1};
      wirq(1'b1);
    end
    apb(1, A_T, 32'h0);
    settle();
    wirq(1'b0);
    apb(1, A_T, 32'h01);
    apb(1, A_C, 32'h4);
    settle();
    wirq(1'b0);
    apb(1, A_C, 32'h7);
    settle();
    wirq(1'b0);
    apb(0, A_C, 32'h7);
    settle();
    chk(exp_q.size(), 33'h0);
    results();
  end
endmodule : bpp_port_test
